// file: verilog/core_memory_cycle_control.sv
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module core_memory_cycle_control (
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_sys_rst,
    input  wire core_cycle_pkg::bus_req_s   i_bus,
    input  wire logic [15:0]                i_sense,
    input  wire logic [3:0]                 i_reg_addr,
    input  wire logic [31:0]                i_reg_wdata,
    input  wire logic                       i_reg_wr,
    input  wire logic                       i_reg_rd,
    output logic [31:0]                     o_reg_rdata,
    output logic                            o_ssyn,
    output logic                            o_data_out_en,
    output logic [15:0]                     o_rdata,
    output core_cycle_pkg::core_drive_s     o_drive,
    output logic [15:0]                     o_inhibit,
    output logic [1:0]                      o_hold_clear,
    output logic [1:0]                      o_sense_strobe
);

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_READ,
        PH_WRITE
    } phase_e;

    phase_e                     state_reg;
    logic [2:0]                 cnt_reg;
    logic                       cycle_lockout_flag;
    logic                       delay_start_flag;
    logic                       rw_flag;
    logic                       skip_flag;
    logic                       ssyn_reg;
    logic                       served_reg;
    logic                       tick2_reg;
    logic [15:0]                hold_register;
    core_cycle_pkg::bus_mode_e  mode_reg;
    logic                       a0_reg;
    logic                       wide_drive_pulse;
    logic                       narrow_drive_pulse;
    logic [2:0]                 strobe_off_reg;
    logic [31:0]                rdata_reg;

    logic       start_cycle;
    logic       read_done;
    logic       write_done;
    logic       is_write;
    logic       is_byte;
    logic       strobe_now;
    logic       clear_now;
    logic       ssyn_set;
    logic       slave_sync_release;
    logic       delay_flag_clear;
    logic       lockout_clear;
    logic [1:0] byte_load;
    logic [1:0] sense_mask;
    logic       low_inhibit_enable;
    logic       high_inhibit_enable;
    logic [15:0] sense_bits;

    // a request counts once per msyn assertion, so a master that holds
    // msyn through the restore does not retrigger a second cycle
    assign start_cycle = (state_reg == PH_IDLE) && !cycle_lockout_flag
                         && i_bus.msyn && !served_reg;
    assign is_write    = mode_reg[1];
    assign is_byte     = mode_reg == core_cycle_pkg::MODE_WRITE_BYTE;

    // bytes that are read back into the hold register: all for reads,
    // none for word writes, the unselected one for byte writes
    always_comb begin
        if (!is_write) begin
            sense_mask = 2'h3;
        end else if (is_byte) begin
            sense_mask = a0_reg ? 2'h1 : 2'h2;
        end else begin
            sense_mask = 2'h0;
        end
    end

    always_comb begin
        if (tick2_reg && is_write) begin
            if (is_byte) begin
                byte_load = a0_reg ? 2'h2 : 2'h1;
            end else begin
                byte_load = 2'h3;
            end
        end else begin
            byte_load = 2'h0;
        end
    end

    assign clear_now  = (state_reg == PH_READ) && rw_flag
                        && cnt_reg == core_cycle_pkg::T_HOLD_CLEAR;
    assign strobe_now = (state_reg == PH_READ) && rw_flag && cnt_reg == strobe_off_reg;
    assign read_done  = (state_reg == PH_READ) && !rw_flag;
    assign write_done = (state_reg == PH_WRITE)
                        && cnt_reg == core_cycle_pkg::T_LOCK_CLEAR;
    assign delay_flag_clear = (state_reg == PH_READ
                               && cnt_reg == core_cycle_pkg::T_RD_DEL_CLEAR)
                              || (state_reg == PH_WRITE
                               && cnt_reg == core_cycle_pkg::T_WR_DEL_CLEAR);
    assign lockout_clear = write_done || (read_done && skip_flag);

    // sync rises on the strobe for reads, on tick two for writes
    assign ssyn_set = !is_write ? (strobe_now && sense_mask != 2'h0)
                                : tick2_reg;
    assign slave_sync_release = ssyn_reg && !i_bus.msyn;

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            state_reg <= PH_IDLE;
            cnt_reg   <= 3'h0;
        end else if (start_cycle) begin
            state_reg <= skip_flag ? PH_WRITE : PH_READ;
            cnt_reg   <= 3'h0;
        end else if (read_done) begin
            state_reg <= skip_flag ? PH_IDLE : PH_WRITE;
            cnt_reg   <= 3'h0;
        end else if (write_done) begin
            state_reg <= PH_IDLE;
        end else if (state_reg != PH_IDLE && cnt_reg != 3'h7) begin
            cnt_reg <= cnt_reg + 3'h1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            delay_start_flag <= 1'b0;
        end else if (start_cycle || (read_done && !skip_flag)) begin
            delay_start_flag <= 1'b1;
        end else if (delay_flag_clear) begin
            delay_start_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            rw_flag <= 1'b0;
        end else if (start_cycle) begin
            rw_flag <= !skip_flag;
        end else if (state_reg == PH_READ && cnt_reg == core_cycle_pkg::T_RW_CLEAR) begin
            rw_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            tick2_reg <= 1'b0;
        end else begin
            tick2_reg <= start_cycle;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            cycle_lockout_flag <= 1'b0;
        end else if (tick2_reg) begin
            cycle_lockout_flag <= 1'b1;
        end else if (lockout_clear) begin
            cycle_lockout_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            served_reg <= 1'b0;
        end else if (start_cycle) begin
            served_reg <= 1'b1;
        end else if (!i_bus.msyn) begin
            served_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            mode_reg <= core_cycle_pkg::MODE_READ;
            a0_reg   <= 1'b0;
        end else if (start_cycle) begin
            mode_reg <= i_bus.mode;
            a0_reg   <= i_bus.addr0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            ssyn_reg <= 1'b0;
        end else if (ssyn_set) begin
            ssyn_reg <= 1'b1;
        end else if (slave_sync_release) begin
            ssyn_reg <= 1'b0;
        end
    end

    // the skip flag is only touched on the two edges of slave sync; the
    // write that follows a pause keeps it set until its own release
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            skip_flag <= 1'b0;
        end else if (ssyn_set && mode_reg == core_cycle_pkg::MODE_READ_PAUSE) begin
            skip_flag <= 1'b1;
        end else if (slave_sync_release
                     && mode_reg != core_cycle_pkg::MODE_READ_PAUSE) begin
            skip_flag <= 1'b0;
        end
    end

    assign sense_bits = i_sense & {{8{sense_mask[1]}}, {8{sense_mask[0]}}};

    // per byte: load, clear and sense never hit the same byte in one cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            hold_register <= 16'h0000;
        end else begin
            for (int b = 0; b < 2; b++) begin
                if (byte_load[b]) begin
                    hold_register[b*8 +: 8] <= i_bus.data[b*8 +: 8];
                end else if (clear_now && sense_mask[b]) begin
                    hold_register[b*8 +: 8] <= 8'h00;
                end else if (strobe_now) begin
                    hold_register[b*8 +: 8] <= hold_register[b*8 +: 8]
                                               | sense_bits[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            wide_drive_pulse   <= 1'b0;
            narrow_drive_pulse <= 1'b0;
        end else begin
            wide_drive_pulse   <= delay_start_flag && !delay_flag_clear
                                  && cnt_reg >= core_cycle_pkg::T_DRIVE_ON;
            narrow_drive_pulse <= delay_start_flag && !delay_flag_clear
                                  && cnt_reg >= core_cycle_pkg::T_NARROW_ON;
        end
    end

    assign low_inhibit_enable  = wide_drive_pulse && !rw_flag;
    assign high_inhibit_enable = wide_drive_pulse && !rw_flag;
    assign o_inhibit = ~hold_register & {{8{high_inhibit_enable}},
                                         {8{low_inhibit_enable}}};

    assign o_drive.wide         = wide_drive_pulse;
    assign o_drive.narrow       = narrow_drive_pulse;
    assign o_drive.read         = rw_flag;
    assign o_drive.low_inhibit  = low_inhibit_enable;
    assign o_drive.high_inhibit = high_inhibit_enable;
    assign o_hold_clear   = clear_now ? sense_mask : 2'h0;
    assign o_sense_strobe = strobe_now ? sense_mask : 2'h0;
    assign o_ssyn         = ssyn_reg;
    assign o_data_out_en  = ssyn_reg && !is_write;
    assign o_rdata        = hold_register;

    // strobe offset is adjustable like the sense timing trim; values that
    // would fall outside the sense window are refused to avoid a hang
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            strobe_off_reg <= core_cycle_pkg::STROBE_RESET;
        end else if (i_reg_wr && i_reg_addr == core_cycle_pkg::ADDR_STROBE
                     && i_reg_wdata[2:0] >= core_cycle_pkg::T_STROBE_MIN
                     && i_reg_wdata[2:0] <= core_cycle_pkg::T_STROBE_MAX) begin
            strobe_off_reg <= i_reg_wdata[2:0];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (i_reg_rd) begin
            rdata_reg <= 32'h0000_0000;
            if (i_reg_addr == core_cycle_pkg::ADDR_STATUS) begin
                rdata_reg[core_cycle_pkg::STAT_LOCKOUT] <= cycle_lockout_flag;
                rdata_reg[core_cycle_pkg::STAT_DELAY]   <= delay_start_flag;
                rdata_reg[core_cycle_pkg::STAT_RW]      <= rw_flag;
                rdata_reg[core_cycle_pkg::STAT_SKIP]    <= skip_flag;
                rdata_reg[core_cycle_pkg::STAT_SSYN]    <= ssyn_reg;
                rdata_reg[core_cycle_pkg::STAT_ACTIVE]  <= state_reg != PH_IDLE;
            end else if (i_reg_addr == core_cycle_pkg::ADDR_STROBE) begin
                rdata_reg[2:0] <= strobe_off_reg;
            end
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    assign o_reg_rdata = rdata_reg;

    AST_START_SETS: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        start_cycle |=> delay_start_flag && (rw_flag == !$past(skip_flag)))
        else $error("first tick did not set the delay and read/write flags");

    AST_LOCKOUT_TICK2: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        start_cycle |-> ##2 cycle_lockout_flag)
        else $error("lockout not set by the second tick");

    AST_NO_START_LOCKED: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        cycle_lockout_flag |=> $stable(mode_reg) || !$past(state_reg == PH_IDLE))
        else $error("cycle started while locked out");

    AST_SSYN_RELEASE: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (ssyn_reg && !i_bus.msyn && !ssyn_set) |=> !o_ssyn)
        else $error("slave sync not released after msyn dropped");

    AST_DEL_BEFORE_SSYN: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        $rose(ssyn_reg) && !is_write |-> !delay_start_flag && rw_flag)
        else $error("read sync raised before delay flag cleared");

    AST_RESTORE: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (read_done && !skip_flag) |=> state_reg == PH_WRITE && delay_start_flag
                                      && cnt_reg == 3'h0)
        else $error("restore write not triggered");

    AST_PAUSE_NO_RESTORE: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (read_done && skip_flag) |=> state_reg == PH_IDLE && !cycle_lockout_flag
                                     && !delay_start_flag)
        else $error("restore not suppressed after read-pause");

    AST_WRITE_END: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (state_reg == PH_WRITE && cnt_reg == 3'h0 && !tick2_reg) |-> ##7
            !delay_start_flag && !cycle_lockout_flag && state_reg == PH_IDLE)
        else $error("write phase did not release delay and lockout");

    AST_WRITE_ONLY: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (start_cycle && skip_flag) |=> !rw_flag && state_reg == PH_WRITE ##1 o_ssyn)
        else $error("write after pause did not skip the clearing read");

    AST_READ_DATA_OUT: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (strobe_now && !is_write) |=> o_ssyn && o_data_out_en)
        else $error("read strobe did not raise sync and data drivers");

    AST_WRITE_ACK: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (tick2_reg && is_write) |=> o_ssyn && !o_data_out_en)
        else $error("write not acknowledged on the second tick");

    // one cover each for read-restore, read-pause, byte write after a pause and byte merge
    COV_READ: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        read_done && !skip_flag);
    COV_PAUSE: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        read_done && skip_flag);
    COV_BYTE_AFTER_PAUSE: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        start_cycle && skip_flag && i_bus.mode == core_cycle_pkg::MODE_WRITE_BYTE);
    COV_BYTE_MERGE: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        strobe_now && is_byte);

endmodule : core_memory_cycle_control

// file: verilog/core_cycle_pkg.sv
package core_cycle_pkg;

    // bus mode lines {c01, c00}
    typedef enum logic [1:0] {
        MODE_READ       = 2'h0,
        MODE_READ_PAUSE = 2'h1,
        MODE_WRITE_WORD = 2'h2,
        MODE_WRITE_BYTE = 2'h3
    } bus_mode_e;

    typedef struct packed {
        logic        msyn;
        bus_mode_e   mode;
        logic        addr0;
        logic [15:0] data;
    } bus_req_s;

    typedef struct packed {
        logic wide;
        logic narrow;
        logic read;
        logic low_inhibit;
        logic high_inhibit;
    } core_drive_s;

    // timing chain offsets, in system clock cycles from the delay start flag
    localparam logic [2:0] T_HOLD_CLEAR   = 3'h1;
    localparam logic [2:0] T_DRIVE_ON     = 3'h2;
    localparam logic [2:0] T_NARROW_ON    = 3'h3;
    localparam logic [2:0] T_RD_DEL_CLEAR = 3'h4;
    localparam logic [2:0] T_STROBE_MIN   = 3'h5;
    localparam logic [2:0] T_STROBE_MAX   = 3'h6;
    localparam logic [2:0] T_RW_CLEAR     = 3'h7;
    localparam logic [2:0] T_WR_DEL_CLEAR = 3'h5;
    localparam logic [2:0] T_LOCK_CLEAR   = 3'h6;

    localparam logic [2:0] STROBE_RESET   = 3'h5;

    // register byte addresses
    localparam logic [3:0] ADDR_STATUS    = 4'h0;
    localparam logic [3:0] ADDR_STROBE    = 4'h4;

    // status field positions
    localparam int STAT_LOCKOUT = 0;
    localparam int STAT_DELAY   = 1;
    localparam int STAT_RW      = 2;
    localparam int STAT_SKIP    = 3;
    localparam int STAT_SSYN    = 4;
    localparam int STAT_ACTIVE  = 5;

endpackage : core_cycle_pkg

// file: testbench/bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model (
    input  wire logic                        i_clk,
    input  wire logic                        i_rst,
    input  wire logic                        i_start,
    input  wire core_cycle_pkg::bus_mode_e   i_mode,
    input  wire logic                        i_addr0,
    input  wire logic [15:0]                 i_wdata,
    input  wire logic                        i_ssyn,
    input  wire logic                        i_data_out_en,
    input  wire logic [15:0]                 i_rdata,
    input  wire core_cycle_pkg::core_drive_s i_drive,
    input  wire logic [15:0]                 i_inhibit,
    output core_cycle_pkg::bus_req_s         o_bus,
    output logic [15:0]                      o_sense,
    output logic                             o_done,
    output logic [15:0]                      o_rdata,
    output logic [7:0]                       o_lat,
    output logic [15:0]                      o_core
);
    logic                     msyn_reg;
    logic                     wait_rel_reg;
    logic                     was_read_reg;
    logic [15:0]              sensed_reg;
    core_cycle_pkg::bus_req_s req_reg;

    // released data lines float: show the inverse so a stale value cannot pass
    always_comb begin
        o_bus      = req_reg;
        o_bus.msyn = msyn_reg;
        if (!msyn_reg) begin
            o_bus.data = ~req_reg.data;
        end
    end

    always_ff @(posedge i_clk) begin
        o_done <= 1'b0;
        if (i_rst) begin
            msyn_reg     <= 1'b0;
            wait_rel_reg <= 1'b0;
            o_lat        <= 8'h0;
            o_rdata      <= 16'h0;
            req_reg      <= '0;
        end else if (i_start && !msyn_reg && !wait_rel_reg) begin
            msyn_reg     <= 1'b1;
            req_reg.mode <= i_mode;
            req_reg.addr0 <= i_addr0;
            req_reg.data <= i_wdata;
            o_lat        <= 8'h0;
        end else if (msyn_reg) begin
            if (i_ssyn) begin
                // take the data at the acknowledging edge, only then drop sync
                if (i_data_out_en) begin
                    o_rdata <= i_rdata;
                end
                msyn_reg     <= 1'b0;
                wait_rel_reg <= 1'b1;
            end else begin
                o_lat <= o_lat + 8'h1;
            end
        end else if (wait_rel_reg && !i_ssyn) begin
            wait_rel_reg <= 1'b0;
            o_done       <= 1'b1;
        end
    end

    // one core word; a read drive empties it, uninhibited bits are written to one
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            was_read_reg <= 1'b0;
            sensed_reg   <= 16'h0;
            o_core       <= 16'h0;
        end else begin
            was_read_reg <= i_drive.read & i_drive.wide;
            if (i_drive.read && i_drive.wide && !was_read_reg) begin
                sensed_reg <= o_core;
                o_core     <= 16'h0;
            end else if (!i_drive.read && i_drive.wide) begin
                o_core <= o_core | ~i_inhibit;
            end
        end
    end
    assign o_sense = i_drive.read ? sensed_reg : ~sensed_reg;
endmodule : bus_master_model

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic                        clk_sys;
    logic                        sys_rst;
    logic                        start;
    logic                        addr0;
    logic                        done;
    logic                        seen_clr;
    logic                        reg_wr;
    logic                        reg_rd;
    logic                        ssyn;
    logic                        data_out_en;
    logic [3:0]                  reg_addr;
    logic [31:0]                 reg_wdata;
    logic [31:0]                 reg_rdata;
    logic [15:0]                 wdata;
    logic [15:0]                 sense;
    logic [15:0]                 rdata;
    logic [15:0]                 bus_rdata;
    logic [15:0]                 core_word;
    logic [15:0]                 inhibit;
    logic [1:0]                  hold_clear;
    logic [1:0]                  sense_strobe;
    logic [7:0]                  lat;
    logic [6:0]                  seen;
    core_cycle_pkg::bus_mode_e   mode;
    core_cycle_pkg::bus_req_s    bus;
    core_cycle_pkg::core_drive_s drive;
    int                          err_count;
    int                          checked;

    core_memory_cycle_control core_memory_cycle_control_i (
        .i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_bus(bus), .i_sense(sense),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
        .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .o_ssyn(ssyn),
        .o_data_out_en(data_out_en), .o_rdata(rdata), .o_drive(drive), .o_inhibit(inhibit),
        .o_hold_clear(hold_clear), .o_sense_strobe(sense_strobe));

    bus_master_model bus_master_model_i (
        .i_clk(clk_sys), .i_rst(sys_rst), .i_start(start), .i_mode(mode), .i_addr0(addr0),
        .i_wdata(wdata), .i_ssyn(ssyn), .i_data_out_en(data_out_en), .i_rdata(rdata),
        .i_drive(drive), .i_inhibit(inhibit), .o_bus(bus), .o_sense(sense), .o_done(done),
        .o_rdata(bus_rdata), .o_lat(lat), .o_core(core_word));

    initial clk_sys = 1'b0;
    always #2.5 clk_sys = ~clk_sys;

    // per transaction: {narrow, read drive, write drive, hold clear hi/lo, strobe hi/lo}
    initial seen = 7'h0;
    always @(posedge clk_sys) begin
        if (seen_clr) begin
            seen <= 7'h0;
        end else begin
            seen <= seen | {drive.narrow, drive.read & drive.wide, ~drive.read & drive.wide,
                            hold_clear, sense_strobe};
        end
    end

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask : reg_read

    task automatic xfer(input core_cycle_pkg::bus_mode_e m, input logic a0, input logic [15:0] d);
        int n;
        @(posedge clk_sys);
        mode     <= m;
        addr0    <= a0;
        wdata    <= d;
        start    <= 1'b1;
        seen_clr <= 1'b1;
        @(posedge clk_sys);
        start    <= 1'b0;
        seen_clr <= 1'b0;
        for (n = 0; n < 300; n++) begin
            @(posedge clk_sys);
            if (done === 1'b1) break;
        end
        if (n == 300) begin
            chk("bus handshake", 32'h1, 32'h0);
            end_of_test;
        end
    endtask : xfer

    // polls status: the memory cycle may outlast the bus handshake
    task automatic wait_idle;
        logic [31:0] s;
        int          n;
        for (n = 0; n < 100; n++) begin
            reg_read(core_cycle_pkg::ADDR_STATUS, s);
            if (s[core_cycle_pkg::STAT_ACTIVE] === 1'b0 && s[core_cycle_pkg::STAT_LOCKOUT] === 1'b0)
                break;
        end
        if (n == 100) begin
            chk("idle wait", 32'h1, 32'h0);
            end_of_test;
        end
    endtask : wait_idle

    task automatic t_reset_and_regs;
        logic [31:0] d;
        chk("ssyn idle", 32'h0, {31'h0, ssyn});
        reg_read(core_cycle_pkg::ADDR_STATUS, d);
        chk("status idle", 32'h0, d);
        reg_read(core_cycle_pkg::ADDR_STROBE, d);
        chk("strobe reset", 32'h5, d);
        reg_write(core_cycle_pkg::ADDR_STROBE, 32'h6);
        reg_read(core_cycle_pkg::ADDR_STROBE, d);
        chk("strobe 6", 32'h6, d);
        reg_write(core_cycle_pkg::ADDR_STROBE, 32'h7);
        reg_read(core_cycle_pkg::ADDR_STROBE, d);
        chk("strobe 7 ignored", 32'h6, d);
        reg_write(core_cycle_pkg::ADDR_STATUS, 32'hff);
        reg_read(4'h8, d);
        chk("unmapped", 32'h0, d);
        reg_read(core_cycle_pkg::ADDR_STATUS, d);
        chk("status read only", 32'h0, d);
        reg_write(core_cycle_pkg::ADDR_STROBE, 32'h5);
    endtask : t_reset_and_regs

    task automatic t_word_and_read;
        xfer(core_cycle_pkg::MODE_WRITE_WORD, 1'b0, 16'ha5c3);
        wait_idle;
        chk("word write phases", 32'h70, {25'h0, seen});
        chk("core after word", 32'ha5c3, {16'h0, core_word});
        xfer(core_cycle_pkg::MODE_READ, 1'b0, 16'h0);
        chk("read data", 32'ha5c3, {16'h0, bus_rdata});
        wait_idle;
        chk("read phases", 32'h7f, {25'h0, seen});
        chk("core restored", 32'ha5c3, {16'h0, core_word});
    endtask : t_word_and_read

    task automatic t_bytes;
        xfer(core_cycle_pkg::MODE_WRITE_BYTE, 1'b0, 16'h1234);
        wait_idle;
        chk("low byte phases", 32'h7a, {25'h0, seen});
        chk("low byte core", 32'ha534, {16'h0, core_word});
        xfer(core_cycle_pkg::MODE_WRITE_BYTE, 1'b1, 16'h7856);
        wait_idle;
        chk("high byte phases", 32'h75, {25'h0, seen});
        chk("high byte core", 32'h7834, {16'h0, core_word});
    endtask : t_bytes

    task automatic t_pause;
        logic [31:0] s;
        xfer(core_cycle_pkg::MODE_READ_PAUSE, 1'b0, 16'hffff);
        chk("pause data", 32'h7834, {16'h0, bus_rdata});
        wait_idle;
        chk("pause phases", 32'h6f, {25'h0, seen});
        chk("pause core cleared", 32'h0, {16'h0, core_word});
        reg_read(core_cycle_pkg::ADDR_STATUS, s);
        chk("skip set", 32'h1, {31'h0, s[core_cycle_pkg::STAT_SKIP]});
        // a pause is always followed by a write
        xfer(core_cycle_pkg::MODE_WRITE_WORD, 1'b0, 16'h0ff0);
        chk("write ack latency", 32'h2, {24'h0, lat});
        wait_idle;
        chk("write after pause phases", 32'h50, {25'h0, seen});
        chk("write after pause core", 32'h0ff0, {16'h0, core_word});
        reg_read(core_cycle_pkg::ADDR_STATUS, s);
        chk("skip cleared", 32'h0, {31'h0, s[core_cycle_pkg::STAT_SKIP]});
        xfer(core_cycle_pkg::MODE_READ_PAUSE, 1'b0, 16'h0);
        chk("pause data 2", 32'h0ff0, {16'h0, bus_rdata});
        wait_idle;
        xfer(core_cycle_pkg::MODE_WRITE_BYTE, 1'b1, 16'hc355);
        wait_idle;
        chk("byte after pause phases", 32'h50, {25'h0, seen});
        chk("byte after pause core", 32'hc3f0, {16'h0, core_word});
    endtask : t_pause

    task automatic t_lockout_and_strobe;
        logic [7:0] l5;
        logic [7:0] lb;
        xfer(core_cycle_pkg::MODE_READ, 1'b0, 16'h0);
        l5 = lat;
        chk("read ack latency", 32'h7, {24'h0, l5});
        // second request arrives while the restore still holds the lockout
        xfer(core_cycle_pkg::MODE_READ, 1'b0, 16'h0);
        lb = lat;
        chk("lockout delays request", 32'h1, {31'h0, lb > l5});
        chk("read after lockout", 32'hc3f0, {16'h0, bus_rdata});
        wait_idle;
        reg_write(core_cycle_pkg::ADDR_STROBE, 32'h6);
        xfer(core_cycle_pkg::MODE_READ, 1'b0, 16'h0);
        chk("strobe offset latency", 32'h8, {24'h0, lat});
        wait_idle;
        chk("core after late strobe", 32'hc3f0, {16'h0, core_word});
    endtask : t_lockout_and_strobe

    initial begin
        err_count = 0;
        checked   = 0;
        sys_rst   = 1'b1;
        start     = 1'b0;
        seen_clr  = 1'b0;
        mode      = core_cycle_pkg::MODE_READ;
        addr0     = 1'b0;
        wdata     = 16'h0;
        reg_addr  = 4'h0;
        reg_wdata = 32'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset_and_regs;
        t_word_and_read;
        t_bytes;
        t_pause;
        t_lockout_and_strobe;
        end_of_test;
    end
endmodule : testbench
